/* core/dhid_pkg.sv */
// Purpose: shared constants and types of the dual bridge input decoder
// Assumes: chopping oscillator clock of 125 MHz drives the logic
// Notes: output drive encoded as value plus enable per bridge leg
package dhid_pkg;
  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_PS = 8000;
  localparam int unsigned BLANK_SHORT_CLK = 4;
  localparam int unsigned BLANK_LONG_CLK = 6;
  localparam int unsigned ANALOG_BLANK_NS = 400;
  localparam int unsigned ANALOG_BLANK_CYC =
    (ANALOG_BLANK_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned CHOP_FAST_EDGE = 11;
  localparam int unsigned CHOP_PERIOD_CLK = 16;
  localparam logic [3:0] CHOP_CNT_RST = 4'h0;
  localparam logic [2:0] BLANK_CNT_RST = 3'h0;
  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    DHID_CHARGE = 2'b00,
    DHID_SLOW = 2'b01,
    DHID_FAST = 2'b10
  } dhid_phase_t;
  typedef struct packed {
    logic dir_in1;
    logic dir_in2;
    logic brake_n;
  } dhid_chan_in_t;
  typedef struct packed {
    logic pos;
    logic pos_oe;
    logic neg;
    logic neg_oe;
  } dhid_bridge_t;
endpackage

/* core/dhid_chan_decode.sv */
// Purpose: decode one channel's direction and brake inputs
// Assumes: inputs already synchronised
// Notes: purely combinational
`timescale 1ns/100ps
`default_nettype none
module dhid_chan_decode
  import dhid_pkg::*;
(
  input wire dhid_chan_in_t in_i,
  output var dhid_bridge_t drive_o
);
  // ****************************************
  // truth table
  // ****************************************
  always_comb begin
    drive_o = '0;
    if (!in_i.dir_in1 && !in_i.dir_in2) begin
      drive_o = '0;
    end else if (!in_i.brake_n || (in_i.dir_in1 && in_i.dir_in2)) begin
      drive_o = '{pos: 1'b0, pos_oe: 1'b1, neg: 1'b0, neg_oe: 1'b1};
    end else begin
      drive_o = '{pos: in_i.dir_in1, pos_oe: 1'b1, neg: in_i.dir_in2, neg_oe: 1'b1};
    end
  end
endmodule
`default_nettype wire

/* core/dhid_top.sv */
// Purpose: dual H-bridge input decoder with chopping and blanking
// Assumes: host pins asynchronous, comparator asynchronous
// Notes: bridge_merge_sel is a strap, sampled continuously
`timescale 1ns/100ps
`default_nettype none
module dhid_top
  import dhid_pkg::*;
#(
  parameter int unsigned CHOP_PERIOD = CHOP_PERIOD_CLK,
  parameter int unsigned FAST_EDGE = CHOP_FAST_EDGE
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic chan_a_dir_in1_i,
  input wire logic chan_a_dir_in2_i,
  input wire logic chan_a_brake_n_i,
  input wire logic chan_b_dir_in1_i,
  input wire logic chan_b_dir_in2_i,
  input wire logic chan_b_brake_n_i,
  input wire logic blank_len_sel_i,
  input wire logic bridge_merge_sel_i,
  input wire logic current_limit_hit_i,
  output logic chan_a_out_pos_o,
  output logic chan_a_out_pos_oe_o,
  output logic chan_a_out_neg_o,
  output logic chan_a_out_neg_oe_o,
  output logic chan_b_out_pos_o,
  output logic chan_b_out_pos_oe_o,
  output logic chan_b_out_neg_o,
  output logic chan_b_out_neg_oe_o,
  output logic standby_o,
  output logic blank_window_o,
  output logic [1:0] chop_phase_o
);
  localparam int unsigned NSYNC = 9;
  localparam int unsigned ABLANK_W = $clog2(ANALOG_BLANK_CYC + 1);

  if (CHOP_PERIOD != 16 || FAST_EDGE < 2 || FAST_EDGE >= CHOP_PERIOD) begin : g_bad_param
    $error("dhid_top: unsupported chopping parameters");
  end

  // ****************************************
  // input synchronisers
  // ****************************************
  logic [NSYNC-1:0] raw;
  logic [NSYNC-1:0] s1;
  logic [NSYNC-1:0] s2;
  logic [NSYNC-1:0] s3;
  logic [NSYNC-1:0] stable;
  logic [NSYNC-1:0] next_stable;
  assign raw = {current_limit_hit_i, bridge_merge_sel_i, blank_len_sel_i,
                chan_b_brake_n_i, chan_b_dir_in2_i, chan_b_dir_in1_i,
                chan_a_brake_n_i, chan_a_dir_in2_i, chan_a_dir_in1_i};

  always_comb begin
    next_stable = stable;
    for (int i = 0; i < NSYNC; i++) begin
      if (s2[i] == s3[i]) begin
        next_stable[i] = s3[i];
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      stable <= '0;
    end else begin
      s1 <= raw;
      s2 <= s1;
      s3 <= s2;
      stable <= next_stable;
    end
  end

  // ****************************************
  // mode and decode
  // ****************************************
  dhid_chan_in_t in_a;
  dhid_chan_in_t in_b;
  dhid_chan_in_t in_b_eff;
  dhid_bridge_t drv_a;
  dhid_bridge_t drv_b;
  logic merge;
  logic sel_long;
  logic limit_s;
  assign in_a = '{dir_in1: stable[0], dir_in2: stable[1], brake_n: stable[2]};
  assign in_b = '{dir_in1: stable[3], dir_in2: stable[4], brake_n: stable[5]};
  assign sel_long = stable[6];
  assign merge = stable[7];
  assign limit_s = stable[8];

  // merge select picks channel B source
  assign in_b_eff = merge ? in_a : in_b;

  dhid_chan_decode u_dec_a (
    .in_i(in_a),
    .drive_o(drv_a)
  );

  dhid_chan_decode u_dec_b (
    .in_i(in_b_eff),
    .drive_o(drv_b)
  );

  logic sby;
  assign sby = ~|{in_a, in_b};

  // ****************************************
  // chopping sequencer
  // ****************************************
  dhid_phase_t phase;
  dhid_phase_t next_phase;
  logic [3:0] chop_cnt;
  logic [3:0] next_chop_cnt;
  logic [2:0] blank_cnt;
  logic [2:0] next_blank_cnt;
  logic [ABLANK_W-1:0] ablank_cnt;
  logic [ABLANK_W-1:0] next_ablank_cnt;
  logic [3:0] dir_prev;
  logic dir_change;
  logic blank_start;
  logic blank_act;
  logic limit_ok;
  logic [2:0] blank_len;

  assign dir_change = (dir_prev != {in_b[2:1] & {2{~merge}}, in_a[2:1]});
  assign blank_act = (blank_cnt != BLANK_CNT_RST) || (ablank_cnt != '0);
  assign limit_ok = limit_s && !blank_act;
  assign blank_len = sel_long ? 3'(BLANK_LONG_CLK) : 3'(BLANK_SHORT_CLK);

  always_comb begin
    next_phase = phase;
    next_chop_cnt = chop_cnt + 4'h1;
    blank_start = 1'b0;
    case (phase)
      DHID_CHARGE: begin
        if (limit_ok) begin
          next_phase = DHID_SLOW;
        end
      end
      DHID_SLOW: begin
        next_phase = DHID_SLOW;
      end
      DHID_FAST: begin
        next_phase = DHID_FAST;
      end
      default: begin
        next_phase = DHID_CHARGE;
      end
    endcase
    if (phase != DHID_FAST && chop_cnt == 4'(FAST_EDGE - 2)) begin
      next_phase = DHID_FAST;
    end
    if (chop_cnt == 4'(CHOP_PERIOD - 1)) begin
      next_chop_cnt = CHOP_CNT_RST;
      next_phase = DHID_CHARGE;
      blank_start = 1'b1;
    end
    if (dir_change) begin
      blank_start = 1'b1;
    end
    next_blank_cnt = (blank_cnt != BLANK_CNT_RST) ? blank_cnt - 3'h1 : BLANK_CNT_RST;
    next_ablank_cnt = (ablank_cnt != '0) ? ablank_cnt - ABLANK_W'(1) : '0;
    if (blank_start) begin
      next_blank_cnt = blank_len;
      next_ablank_cnt = ABLANK_W'(ANALOG_BLANK_CYC);
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      phase <= DHID_CHARGE;
      chop_cnt <= CHOP_CNT_RST;
      blank_cnt <= BLANK_CNT_RST;
      ablank_cnt <= '0;
      dir_prev <= 4'h0;
    end else begin
      phase <= next_phase;
      chop_cnt <= next_chop_cnt;
      blank_cnt <= next_blank_cnt;
      ablank_cnt <= next_ablank_cnt;
      dir_prev <= {in_b[2:1] & {2{~merge}}, in_a[2:1]};
    end
  end

  // ****************************************
  // output registers
  // ****************************************
  dhid_bridge_t out_a;
  dhid_bridge_t out_b;
  dhid_bridge_t next_out_a;
  dhid_bridge_t next_out_b;
  logic sby_q;
  logic blank_q;

  always_comb begin
    next_out_a = drv_a;
    next_out_b = drv_b;
    if (sby) begin
      next_out_a = '0;
      next_out_b = '0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      out_a <= '0;
      out_b <= '0;
      sby_q <= 1'b1;
      blank_q <= 1'b0;
    end else begin
      out_a <= next_out_a;
      out_b <= next_out_b;
      sby_q <= sby;
      blank_q <= blank_act;
    end
  end

  assign chan_a_out_pos_o = out_a.pos;
  assign chan_a_out_pos_oe_o = out_a.pos_oe;
  assign chan_a_out_neg_o = out_a.neg;
  assign chan_a_out_neg_oe_o = out_a.neg_oe;
  assign chan_b_out_pos_o = out_b.pos;
  assign chan_b_out_pos_oe_o = out_b.pos_oe;
  assign chan_b_out_neg_o = out_b.neg;
  assign chan_b_out_neg_oe_o = out_b.neg_oe;
  assign standby_o = sby_q;
  assign blank_window_o = blank_q;
  assign chop_phase_o = phase;

  // ****************************************
  // assertions
  // ****************************************
  a_fwd_decode: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (in_a.brake_n && in_a.dir_in1 && !in_a.dir_in2) |=>
      (chan_a_out_pos_o && !chan_a_out_neg_o && chan_a_out_pos_oe_o))
    else $error("channel A forward decode wrong");
  a_brake_decode: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (!in_a.brake_n && (in_a.dir_in1 || in_a.dir_in2)) |=>
      (!chan_a_out_pos_o && !chan_a_out_neg_o && chan_a_out_neg_oe_o))
    else $error("channel A short brake wrong");
  a_b_rev_decode: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (!merge && in_b.brake_n && !in_b.dir_in1 && in_b.dir_in2) |=>
      (!chan_b_out_pos_o && chan_b_out_neg_o && chan_b_out_neg_oe_o))
    else $error("channel B reverse decode wrong");
  a_standby_only: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (|{in_a, in_b}) |=> !standby_o)
    else $error("standby with an input high");
  a_short_blank: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (blank_start && !sel_long) ##1 !blank_start [*3] |=>
      (blank_cnt == 3'h1 && $past(blank_cnt, 3) == 3'h4))
    else $error("short blanking length wrong");
  a_long_blank: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (blank_start && sel_long) ##1 !blank_start [*5] |=>
      (blank_cnt == 3'h1))
    else $error("long blanking length wrong");
  a_charge_blank: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (phase != DHID_CHARGE) ##1 (phase == DHID_CHARGE) |-> blank_act)
    else $error("no blanking at charge start");
  a_dir_blank: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    dir_change |=> (blank_cnt != BLANK_CNT_RST))
    else $error("direction change without blanking");
  a_mask_limit: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (phase == DHID_CHARGE && blank_act && chop_cnt < 4'h9) |=> (phase == DHID_CHARGE))
    else $error("comparator honoured during blanking");
  a_large_copy: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    merge |=> (out_b == $past(drv_a) || $past(sby)))
    else $error("large mode not following channel A");
  a_fast_edge: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (chop_cnt == 4'hA) |-> (phase == DHID_FAST))
    else $error("fast decay not at eleventh clock");
  a_period_wrap: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (chop_cnt == 4'hF) |=> (chop_cnt == 4'h0 && phase == DHID_CHARGE))
    else $error("chopping period not sixteen");
  a_slow_trip: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (phase == DHID_CHARGE && limit_ok && chop_cnt < 4'h9) |=> (phase == DHID_SLOW))
    else $error("comparator trip did not slow decay");
  c_slow: cover property (@(posedge clk_i) disable iff (!rst_b_i) phase == DHID_SLOW);
  c_merge: cover property (@(posedge clk_i) disable iff (!rst_b_i) merge && !sby);
  c_dir_blank: cover property (@(posedge clk_i) disable iff (!rst_b_i) dir_change);
endmodule
`default_nettype wire

/* verification/dhid_host_model.sv */
// Purpose: host controller model driving the decoder pins
// Assumes: requests change just after a rising clock edge
// Notes: pins move one edge after a request; strap moves only in reset
`timescale 1ns/100ps
`default_nettype none
module dhid_host_model
  import dhid_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire dhid_chan_in_t a_req_i,
  input wire dhid_chan_in_t b_req_i,
  input wire logic sel_req_i,
  input wire logic merge_req_i,
  input wire logic limit_req_i,
  output var dhid_chan_in_t a_o,
  output var dhid_chan_in_t b_o,
  output var logic sel_o,
  output var logic merge_o,
  output var logic limit_o
);
  // ****************************************
  // pin drive
  // ****************************************
  initial begin
    a_o = '0;
    b_o = '0;
    sel_o = 1'b0;
    merge_o = 1'b0;
    limit_o = 1'b0;
  end
  always @(posedge clk_i) begin
    a_o <= a_req_i;
    sel_o <= sel_req_i;
    limit_o <= limit_req_i;
    b_o <= merge_o ? dhid_chan_in_t'(3'h0) : b_req_i;
    if (!rst_b_i) begin
      merge_o <= merge_req_i;
    end
  end
endmodule
`default_nettype wire

/* verification/dhid_top_tb.sv */
// Purpose: self-checking bench of the dual bridge input decoder
// Assumes: 125 MHz clock, pins driven through the host model
// Notes: outputs judged 8 edges after each drive or reset request; chopping judged from 65 edges after its request
`timescale 1ns/100ps
`default_nettype none
module dhid_top_tb;
  import dhid_pkg::*;
  // ****************************************
  // signals
  // ****************************************
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  dhid_chan_in_t a_req = '0;
  dhid_chan_in_t b_req = '0;
  logic sel_req = 1'b0;
  logic merge_req = 1'b0;
  logic limit_req = 1'b0;
  dhid_chan_in_t a_pin;
  dhid_chan_in_t b_pin;
  logic sel_pin;
  logic merge_pin;
  logic limit_pin;
  wire dhid_bridge_t leg_a;
  wire dhid_bridge_t leg_b;
  logic standby;
  logic blank;
  logic [1:0] phase;
  int failures = 0;
  int n_tests = 0;
  always #4 clk = ~clk;
  dhid_host_model host (.clk_i(clk), .rst_b_i(rst_b), .a_req_i(a_req), .b_req_i(b_req),
    .sel_req_i(sel_req), .merge_req_i(merge_req), .limit_req_i(limit_req), .a_o(a_pin),
    .b_o(b_pin), .sel_o(sel_pin), .merge_o(merge_pin), .limit_o(limit_pin));
  dhid_top dut (.clk_i(clk), .rst_b_i(rst_b), .chan_a_dir_in1_i(a_pin.dir_in1),
    .chan_a_dir_in2_i(a_pin.dir_in2), .chan_a_brake_n_i(a_pin.brake_n),
    .chan_b_dir_in1_i(b_pin.dir_in1), .chan_b_dir_in2_i(b_pin.dir_in2),
    .chan_b_brake_n_i(b_pin.brake_n), .blank_len_sel_i(sel_pin),
    .bridge_merge_sel_i(merge_pin), .current_limit_hit_i(limit_pin),
    .chan_a_out_pos_o(leg_a.pos), .chan_a_out_pos_oe_o(leg_a.pos_oe),
    .chan_a_out_neg_o(leg_a.neg), .chan_a_out_neg_oe_o(leg_a.neg_oe),
    .chan_b_out_pos_o(leg_b.pos), .chan_b_out_pos_oe_o(leg_b.pos_oe),
    .chan_b_out_neg_o(leg_b.neg), .chan_b_out_neg_oe_o(leg_b.neg_oe),
    .standby_o(standby), .blank_window_o(blank), .chop_phase_o(phase));
  // ****************************************
  // helpers
  // ****************************************
  task automatic end_of_test;
    if (failures == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk_leg(input dhid_bridge_t got, input dhid_bridge_t exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_num(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic dhid_bridge_t mask_leg(input dhid_bridge_t d);
    return {d.pos & d.pos_oe, d.pos_oe, d.neg & d.neg_oe, d.neg_oe};
  endfunction
  function automatic dhid_bridge_t exp_leg(input dhid_chan_in_t c);
    if (!c.dir_in1 && !c.dir_in2) begin
      return 4'h0;
    end
    if (!c.brake_n || (c.dir_in1 && c.dir_in2)) begin
      return 4'h5;
    end
    return c.dir_in1 ? 4'hD : 4'h7;
  endfunction
  task automatic drive(input logic [2:0] a, input logic [2:0] b);
    @(posedge clk);
    a_req <= dhid_chan_in_t'(a);
    b_req <= dhid_chan_in_t'(b);
    repeat (8) @(posedge clk);
    #1;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic do_reset(input logic merge);
    @(posedge clk);
    a_req <= dhid_chan_in_t'(3'h5);
    merge_req <= merge;
    limit_req <= 1'b1;
    rst_b <= 1'b0;
    repeat (8) @(posedge clk);
    #1;
    chk_leg(leg_a, 4'h0);
    chk_leg(leg_b, 4'h0);
    chk_num({6'h00, phase}, 8'h00);
    @(posedge clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge clk);
    #1;
    chk_num({6'h00, phase}, 8'(DHID_SLOW));
  endtask
  task automatic t_decode(input logic chan_b);
    for (int i = 0; i < 8; i++) begin
      if (chan_b) begin
        drive(3'h1, 3'(i));
        chk_leg(mask_leg(leg_b), exp_leg(b_req));
      end else begin
        drive(3'(i), 3'h1);
        chk_leg(mask_leg(leg_a), exp_leg(a_req));
      end
    end
  endtask
  task automatic t_standby;
    logic [5:0] v;
    for (int k = 0; k < 7; k++) begin
      v = (k == 6) ? 6'h00 : 6'(1 << k);
      drive(v[5:3], v[2:0]);
      chk_num({7'h00, standby}, {7'h00, k == 6});
    end
    chk_leg(mask_leg(leg_a), 4'h0);
  endtask
  task automatic t_large;
    for (int i = 0; i < 8; i++) begin
      drive(3'(i), 3'h6);
      chk_leg(mask_leg(leg_a), exp_leg(a_req));
      chk_leg(mask_leg(leg_b), exp_leg(a_req));
      chk_num({7'h00, standby}, {7'h00, i == 0});
    end
  endtask
  task automatic t_chop(input logic sel);
    int n_fast;
    int n_chg;
    int n_slow;
    int n_low;
    n_fast = 0;
    n_chg = 0;
    n_slow = 0;
    n_low = 0;
    @(posedge clk);
    sel_req <= sel;
    limit_req <= 1'b1;
    repeat (64) @(posedge clk);
    for (int i = 0; i < 2 * CHOP_PERIOD_CLK; i++) begin
      @(posedge clk);
      #1;
      n_fast += (phase === DHID_FAST);
      n_chg += (phase === DHID_CHARGE);
      n_slow += (phase === DHID_SLOW);
      n_low += (blank !== 1'b1);
    end
    chk_num(8'(n_fast), 8'(2 * (CHOP_PERIOD_CLK - CHOP_FAST_EDGE + 1)));
    chk_num(8'(n_chg), 8'(2 * (CHOP_FAST_EDGE - 1)));
    chk_num(8'(n_slow), 8'h00);
    chk_num(8'(n_low), 8'h00);
    limit_req <= 1'b0;
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    do_reset(1'b0);
    t_decode(1'b0);
    t_decode(1'b1);
    t_standby;
    t_chop(1'b0);
    t_chop(1'b1);
    do_reset(1'b1);
    t_large;
    t_chop(1'b0);
    t_chop(1'b1);
    end_of_test;
  end
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    end_of_test;
  end
endmodule
`default_nettype wire
